// ===== common/status_reply_pkg.sv
/*
  Shared constants for the status reply formatter: register map, field
  positions, reset values, display command codes and reply characters.
  Assumes a byte-wide reply stream and command codes that are the hex
  command numbers held in binary.
*/
// Function
// - Control field C0 host, C1 predefined mode
// - Output field O0..O3 from output states
// - Input field I0..I3 from input states
// - Pulse field one hex digit, E undefined
// - Radio reply field order; C1 means presence-driven
// - Radio O0/O1; uniqueness codes T1..T3 only
// - Two range fields, hex 00 to 1F
// - Two attenuation fields, 00 to 06
// - Presence report field P1 enabled, P0 disabled
// - Presence minimum period always D0
// - Shut-off field A0, A1, A2
// - Radio timeout one hex digit, T0 always expired
// - Timeout TF infinite, factory default
// - Inversion field I0 default, I1 enabled
// - Separation U0..U3, U4 transmit all
// - Validity V0..V3 acquisitions
// - Tag-output mode single digit 0 or 1
// - Retransmit interval two hex digits 01..FF
// - Reply is tag then spaced letter-value fields; tag-output and interval replies give a bare value
package status_reply_pkg;

  // Register byte offsets
  localparam logic [7:0] IO_CFG_OFS = 8'h00;
  localparam logic [7:0] RF_CFG_OFS = 8'h04;
  localparam logic [7:0] PRES_CFG_OFS = 8'h08;
  localparam logic [7:0] FILT_CFG_OFS = 8'h0C;
  localparam logic [7:0] OUT_CFG_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;

  // Writable bit masks, one per register except status
  localparam logic [31:0] IO_CFG_MASK = 32'h000000F7;
  localparam logic [31:0] RF_CFG_MASK = 32'h771F1F0F;
  localparam logic [31:0] PRES_CFG_MASK = 32'h000001F7;
  localparam logic [31:0] FILT_CFG_MASK = 32'h00000037;
  localparam logic [31:0] OUT_CFG_MASK = 32'h0000FF01;

  // Reset values
  localparam logic [31:0] IO_CFG_RST = 32'h00000000;
  localparam logic [31:0] RF_CFG_RST = 32'h00000004;
  localparam logic [31:0] PRES_CFG_RST = 32'h000000F0;
  localparam logic [31:0] FILT_CFG_RST = 32'h00000000;
  localparam logic [31:0] OUT_CFG_RST = 32'h00000100;

  // Field positions
  localparam int IO_CTRL_BIT = 0;
  localparam int IO_OUTS_LSB = 1;
  localparam int IO_PULSE_LSB = 4;
  localparam int RF_CTRL_BIT = 0;
  localparam int RF_ON_BIT = 1;
  localparam int RF_UNIQ_LSB = 2;
  localparam int RF_RANGE_A_LSB = 8;
  localparam int RF_RANGE_B_LSB = 16;
  localparam int RF_ATT_A_LSB = 24;
  localparam int RF_ATT_B_LSB = 28;
  localparam int PRES_RPT_BIT = 0;
  localparam int PRES_SHUT_LSB = 1;
  localparam int PRES_TO_LSB = 4;
  localparam int PRES_INV_BIT = 8;
  localparam int FILT_SEP_LSB = 0;
  localparam int FILT_VAL_LSB = 4;
  localparam int OUT_MODE_BIT = 0;
  localparam int OUT_IVL_LSB = 8;

  // Field limits
  localparam logic [3:0] PULSE_UNDEF = 4'hE;
  localparam logic [1:0] UNIQ_MIN = 2'h1;
  localparam logic [2:0] ATT_MAX = 3'h6;
  localparam logic [1:0] SHUT_MAX = 2'h2;
  localparam logic [2:0] SEP_MAX = 3'h4;
  localparam logic [7:0] IVL_MIN = 8'h01;
  localparam logic [3:0] TO_INFINITE = 4'hF;

  // Display command numbers
  localparam logic [11:0] CMD_IO = 12'h20E;
  localparam logic [11:0] CMD_RF = 12'h20F;
  localparam logic [11:0] CMD_PRES = 12'h211;
  localparam logic [11:0] CMD_FILT = 12'h212;
  localparam logic [11:0] CMD_TAG_OUT = 12'h214;
  localparam logic [11:0] CMD_RETX = 12'h215;

  // Reply tags in ASCII
  localparam logic [31:0] IO_STATE_REPLY_TAG = 32'h494F5354;
  localparam logic [31:0] RADIO_STATE_REPLY_TAG = 32'h52465354;
  localparam logic [31:0] PRESENCE_STATE_REPLY_TAG = 32'h50525354;
  localparam logic [31:0] ID_FILTER_REPLY_TAG = 32'h52463053;
  localparam logic [23:0] SERIAL_TAG_OUTPUT_MODE_TAG = 24'h544F46;
  localparam logic [23:0] RETRANSMIT_INTERVAL_TAG = 24'h575449;

  // Reply characters
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_D = 8'h44;
  localparam logic [7:0] CH_F = 8'h46;
  localparam logic [7:0] CH_G = 8'h47;
  localparam logic [7:0] CH_I = 8'h49;
  localparam logic [7:0] CH_O = 8'h4F;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_T = 8'h54;
  localparam logic [7:0] CH_U = 8'h55;
  localparam logic [7:0] CH_V = 8'h56;

  // Reply lengths in bytes, line end included
  localparam int LINE_BYTES = 36;
  localparam logic [5:0] LEN_IO = 6'h12;
  localparam logic [5:0] LEN_RF = 6'h24;
  localparam logic [5:0] LEN_PRES = 6'h15;
  localparam logic [5:0] LEN_FILT = 6'h0C;
  localparam logic [5:0] LEN_TAG_OUT = 6'h07;
  localparam logic [5:0] LEN_RETX = 6'h08;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } reply_state_e;

  typedef enum logic [2:0] {
    K_IO = 3'b000,
    K_RF = 3'b001,
    K_PRES = 3'b010,
    K_FILT = 3'b011,
    K_TAG_OUT = 3'b100,
    K_RETX = 3'b101
  } reply_kind_e;

endpackage

// ===== verilog/status_reply_formatter.sv
/*
  Status reply formatter: holds the reported configuration in APB
  registers and, on one of six display commands, streams the fixed-format
  ASCII reply one byte at a time, closed by CR LF.
  Assumes the command front end and the serial transmitter share REF_CLK;
  the two input pins are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none

module status_reply_formatter (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SRST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Display command from the parser
  input wire logic CMD_VALID,
  input wire logic [11:0] CMD_CODE,
  output logic CMD_READY,
  // Reply byte stream to the serial transmitter
  output logic TX_VALID,
  output logic [7:0] TX_DATA,
  input wire logic TX_READY,
  // Asynchronous input pins
  input wire logic [1:0] IN_PIN
);

  typedef struct packed {
    status_reply_pkg::reply_state_e st;
    status_reply_pkg::reply_kind_e kind;
    logic [5:0] idx;
    logic [7:0] tx_data;
    logic tx_valid;
    logic [31:0] prdata;
    logic [31:0] io_cfg;
    logic [31:0] rf_cfg;
    logic [31:0] pres_cfg;
    logic [31:0] filt_cfg;
    logic [31:0] out_cfg;
    logic [1:0] in_meta;
    logic [1:0] in_sync;
  } state_s;

  state_s s_reg;
  state_s s_next;

  // One hex digit as ASCII
  function automatic logic [7:0] hex_ch(input logic [3:0] v);
    hex_ch = (v < 4'hA) ? (8'h30 + {4'h0, v}) : (8'h37 + {4'h0, v});
  endfunction

  // Byte count of each reply
  function automatic logic [5:0] reply_len(
    input status_reply_pkg::reply_kind_e k);
    case (k)
      status_reply_pkg::K_IO: reply_len = status_reply_pkg::LEN_IO;
      status_reply_pkg::K_RF: reply_len = status_reply_pkg::LEN_RF;
      status_reply_pkg::K_PRES: reply_len = status_reply_pkg::LEN_PRES;
      status_reply_pkg::K_FILT: reply_len = status_reply_pkg::LEN_FILT;
      status_reply_pkg::K_TAG_OUT: reply_len = status_reply_pkg::LEN_TAG_OUT;
      default: reply_len = status_reply_pkg::LEN_RETX;
    endcase
  endfunction

  // Register field views
  logic io_ctrl;
  logic [1:0] io_outs;
  logic [3:0] io_pulse;
  logic rf_ctrl;
  logic rf_on;
  logic [1:0] rf_uniq;
  logic [4:0] rf_range_a;
  logic [4:0] rf_range_b;
  logic [2:0] rf_att_a;
  logic [2:0] rf_att_b;
  logic pres_rpt;
  logic [1:0] pres_shut;
  logic [3:0] pres_to;
  logic pres_inv;
  logic [2:0] filt_sep;
  logic [1:0] filt_val;
  logic out_mode;
  logic [7:0] out_ivl;
  logic [1:0] in_shown;

  assign io_ctrl = s_reg.io_cfg[status_reply_pkg::IO_CTRL_BIT];
  assign io_outs = s_reg.io_cfg[status_reply_pkg::IO_OUTS_LSB +: 2];
  assign io_pulse = s_reg.io_cfg[status_reply_pkg::IO_PULSE_LSB +: 4];
  assign rf_ctrl = s_reg.rf_cfg[status_reply_pkg::RF_CTRL_BIT];
  assign rf_on = s_reg.rf_cfg[status_reply_pkg::RF_ON_BIT];
  assign rf_uniq = s_reg.rf_cfg[status_reply_pkg::RF_UNIQ_LSB +: 2];
  assign rf_range_a = s_reg.rf_cfg[status_reply_pkg::RF_RANGE_A_LSB +: 5];
  assign rf_range_b = s_reg.rf_cfg[status_reply_pkg::RF_RANGE_B_LSB +: 5];
  assign rf_att_a = s_reg.rf_cfg[status_reply_pkg::RF_ATT_A_LSB +: 3];
  assign rf_att_b = s_reg.rf_cfg[status_reply_pkg::RF_ATT_B_LSB +: 3];
  assign pres_rpt = s_reg.pres_cfg[status_reply_pkg::PRES_RPT_BIT];
  assign pres_shut = s_reg.pres_cfg[status_reply_pkg::PRES_SHUT_LSB +: 2];
  assign pres_to = s_reg.pres_cfg[status_reply_pkg::PRES_TO_LSB +: 4];
  assign pres_inv = s_reg.pres_cfg[status_reply_pkg::PRES_INV_BIT];
  assign filt_sep = s_reg.filt_cfg[status_reply_pkg::FILT_SEP_LSB +: 3];
  assign filt_val = s_reg.filt_cfg[status_reply_pkg::FILT_VAL_LSB +: 2];
  assign out_mode = s_reg.out_cfg[status_reply_pkg::OUT_MODE_BIT];
  assign out_ivl = s_reg.out_cfg[status_reply_pkg::OUT_IVL_LSB +: 8];
  // Input state in the IO reply follows the inversion setting
  assign in_shown = s_reg.in_sync ^ {2{pres_inv}};

  // Whole reply line, left aligned, zero padded
  logic [status_reply_pkg::LINE_BYTES*8-1:0] line;
  always_comb begin
    case (s_reg.kind)
      status_reply_pkg::K_IO: begin
        line = {status_reply_pkg::IO_STATE_REPLY_TAG,
          status_reply_pkg::CH_SP, status_reply_pkg::CH_C,
          hex_ch({3'h0, io_ctrl}),
          status_reply_pkg::CH_SP, status_reply_pkg::CH_O,
          hex_ch({2'h0, io_outs}),
          status_reply_pkg::CH_SP, status_reply_pkg::CH_I,
          hex_ch({2'h0, in_shown}),
          status_reply_pkg::CH_SP, status_reply_pkg::CH_D,
          hex_ch(io_pulse),
          status_reply_pkg::CH_CR, status_reply_pkg::CH_LF, 144'h0};
      end
      status_reply_pkg::K_RF: begin
        line = {status_reply_pkg::RADIO_STATE_REPLY_TAG,
          status_reply_pkg::CH_SP, status_reply_pkg::CH_C,
          hex_ch({3'h0, rf_ctrl}),
          status_reply_pkg::CH_SP, status_reply_pkg::CH_O,
          hex_ch({3'h0, rf_on}),
          status_reply_pkg::CH_SP, status_reply_pkg::CH_T,
          hex_ch({2'h0, rf_uniq}),
          status_reply_pkg::CH_SP, status_reply_pkg::CH_F,
          {3{status_reply_pkg::CH_ZERO}}, // Unused field, fixed
          status_reply_pkg::CH_SP, status_reply_pkg::CH_R,
          hex_ch({3'h0, rf_range_a[4]}), hex_ch(rf_range_a[3:0]),
          status_reply_pkg::CH_SP, status_reply_pkg::CH_G,
          hex_ch({3'h0, rf_range_b[4]}), hex_ch(rf_range_b[3:0]),
          status_reply_pkg::CH_SP, status_reply_pkg::CH_A,
          status_reply_pkg::CH_ZERO, hex_ch({1'h0, rf_att_a}),
          status_reply_pkg::CH_SP, status_reply_pkg::CH_I,
          status_reply_pkg::CH_ZERO, hex_ch({1'h0, rf_att_b}),
          status_reply_pkg::CH_CR, status_reply_pkg::CH_LF};
      end
      status_reply_pkg::K_PRES: begin
        line = {status_reply_pkg::PRESENCE_STATE_REPLY_TAG,
          status_reply_pkg::CH_SP, status_reply_pkg::CH_P,
          hex_ch({3'h0, pres_rpt}),
          status_reply_pkg::CH_SP, status_reply_pkg::CH_D,
          status_reply_pkg::CH_ZERO,
          status_reply_pkg::CH_SP, status_reply_pkg::CH_A,
          hex_ch({2'h0, pres_shut}),
          status_reply_pkg::CH_SP, status_reply_pkg::CH_T,
          hex_ch(pres_to),
          status_reply_pkg::CH_SP, status_reply_pkg::CH_I,
          hex_ch({3'h0, pres_inv}),
          status_reply_pkg::CH_CR, status_reply_pkg::CH_LF, 120'h0};
      end
      status_reply_pkg::K_FILT: begin
        line = {status_reply_pkg::ID_FILTER_REPLY_TAG,
          status_reply_pkg::CH_SP, status_reply_pkg::CH_U,
          hex_ch({1'h0, filt_sep}),
          status_reply_pkg::CH_SP, status_reply_pkg::CH_V,
          hex_ch({2'h0, filt_val}),
          status_reply_pkg::CH_CR, status_reply_pkg::CH_LF, 192'h0};
      end
      status_reply_pkg::K_TAG_OUT: begin
        line = {status_reply_pkg::SERIAL_TAG_OUTPUT_MODE_TAG,
          status_reply_pkg::CH_SP, hex_ch({3'h0, out_mode}),
          status_reply_pkg::CH_CR, status_reply_pkg::CH_LF, 232'h0};
      end
      default: begin
        line = {status_reply_pkg::RETRANSMIT_INTERVAL_TAG,
          status_reply_pkg::CH_SP,
          hex_ch(out_ivl[7:4]), hex_ch(out_ivl[3:0]),
          status_reply_pkg::CH_CR, status_reply_pkg::CH_LF, 224'h0};
      end
    endcase
  end

  // Byte of the current kind at a given position
  function automatic logic [7:0] pick(
    input logic [status_reply_pkg::LINE_BYTES*8-1:0] l,
    input logic [5:0] i);
    pick = l[(status_reply_pkg::LINE_BYTES - 1 - int'(i)) * 8 +: 8];
  endfunction

  // Bus decode; access phase always completes at once
  logic wr_acc;
  logic addr_ok;
  logic cmd_take;
  logic tx_last;
  assign addr_ok = (PADDR <= status_reply_pkg::STATUS_OFS)
    && (PADDR[1:0] == 2'b00);
  assign wr_acc = PSEL && PENABLE && PWRITE && addr_ok;
  assign PREADY = PSEL && PENABLE;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;
  assign PRDATA = s_reg.prdata;
  assign CMD_READY = (s_reg.st == status_reply_pkg::ST_IDLE);
  assign cmd_take = CMD_VALID && CMD_READY;
  assign TX_VALID = s_reg.tx_valid;
  assign TX_DATA = s_reg.tx_data;
  assign tx_last = s_reg.tx_valid && TX_READY
    && (s_reg.idx == reply_len(s_reg.kind) - 6'h01);

  // Next state: pins, registers, reply sequencer
  status_reply_pkg::reply_kind_e cmd_kind;
  logic cmd_hit;
  logic [31:0] wv;
  always_comb begin
    s_next = s_reg;
    wv = PWDATA;
    cmd_hit = 1'b1;
    cmd_kind = status_reply_pkg::K_IO;
    // Two-flop synchroniser on the pins
    s_next.in_meta = IN_PIN;
    s_next.in_sync = s_reg.in_meta;

    // Read data captured in setup phase, shown in access phase
    if (PSEL && !PENABLE) begin
      case (PADDR)
        status_reply_pkg::IO_CFG_OFS: s_next.prdata = s_reg.io_cfg;
        status_reply_pkg::RF_CFG_OFS: s_next.prdata = s_reg.rf_cfg;
        status_reply_pkg::PRES_CFG_OFS: s_next.prdata = s_reg.pres_cfg;
        status_reply_pkg::FILT_CFG_OFS: s_next.prdata = s_reg.filt_cfg;
        status_reply_pkg::OUT_CFG_OFS: s_next.prdata = s_reg.out_cfg;
        status_reply_pkg::STATUS_OFS: begin
          s_next.prdata = {28'h0, s_reg.in_sync, 1'b0,
            s_reg.st == status_reply_pkg::ST_SEND};
        end
        default: s_next.prdata = 32'h00000000;
      endcase
    end

    // Writes; illegal codes are refused so replies stay in range
    if (wr_acc) begin
      case (PADDR)
        status_reply_pkg::IO_CFG_OFS: begin
          if (wv[status_reply_pkg::IO_PULSE_LSB +: 4]
              != status_reply_pkg::PULSE_UNDEF) begin
            s_next.io_cfg = wv & status_reply_pkg::IO_CFG_MASK;
          end
        end
        status_reply_pkg::RF_CFG_OFS: begin
          if (wv[status_reply_pkg::RF_UNIQ_LSB +: 2]
              >= status_reply_pkg::UNIQ_MIN
              && wv[status_reply_pkg::RF_ATT_A_LSB +: 3]
              <= status_reply_pkg::ATT_MAX
              && wv[status_reply_pkg::RF_ATT_B_LSB +: 3]
              <= status_reply_pkg::ATT_MAX) begin
            s_next.rf_cfg = wv & status_reply_pkg::RF_CFG_MASK;
          end
        end
        status_reply_pkg::PRES_CFG_OFS: begin
          if (wv[status_reply_pkg::PRES_SHUT_LSB +: 2]
              <= status_reply_pkg::SHUT_MAX) begin
            s_next.pres_cfg = wv & status_reply_pkg::PRES_CFG_MASK;
          end
        end
        status_reply_pkg::FILT_CFG_OFS: begin
          if (wv[status_reply_pkg::FILT_SEP_LSB +: 3]
              <= status_reply_pkg::SEP_MAX) begin
            s_next.filt_cfg = wv & status_reply_pkg::FILT_CFG_MASK;
          end
        end
        status_reply_pkg::OUT_CFG_OFS: begin
          if (wv[status_reply_pkg::OUT_IVL_LSB +: 8]
              >= status_reply_pkg::IVL_MIN) begin
            s_next.out_cfg = wv & status_reply_pkg::OUT_CFG_MASK;
          end
        end
        default: s_next.out_cfg = s_reg.out_cfg;
      endcase
    end

    // Command match; other codes are swallowed without a reply
    case (CMD_CODE)
      status_reply_pkg::CMD_IO: cmd_kind = status_reply_pkg::K_IO;
      status_reply_pkg::CMD_RF: cmd_kind = status_reply_pkg::K_RF;
      status_reply_pkg::CMD_PRES: cmd_kind = status_reply_pkg::K_PRES;
      status_reply_pkg::CMD_FILT: cmd_kind = status_reply_pkg::K_FILT;
      status_reply_pkg::CMD_TAG_OUT: cmd_kind = status_reply_pkg::K_TAG_OUT;
      status_reply_pkg::CMD_RETX: cmd_kind = status_reply_pkg::K_RETX;
      default: cmd_hit = 1'b0;
    endcase

    // Sequencer; first byte is loaded the edge after the line is built
    case (s_reg.st)
      status_reply_pkg::ST_IDLE: begin
        if (cmd_take && cmd_hit) begin
          s_next.st = status_reply_pkg::ST_SEND;
          s_next.kind = cmd_kind;
          s_next.idx = 6'h00;
          s_next.tx_valid = 1'b0;
        end
      end
      status_reply_pkg::ST_SEND: begin
        if (!s_reg.tx_valid) begin
          s_next.tx_data = pick(line, s_reg.idx);
          s_next.tx_valid = 1'b1;
        end else if (tx_last) begin
          s_next.st = status_reply_pkg::ST_IDLE;
          s_next.tx_valid = 1'b0;
        end else if (TX_READY) begin
          s_next.idx = s_reg.idx + 6'h01;
          s_next.tx_data = pick(line, s_reg.idx + 6'h01);
        end
      end
      default: s_next.st = status_reply_pkg::ST_IDLE;
    endcase
  end

  // State register; pulse code 0, timeout TF after reset
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      s_reg <= '{st: status_reply_pkg::ST_IDLE,
        kind: status_reply_pkg::K_IO,
        idx: 6'h00, tx_data: 8'h00, tx_valid: 1'b0, prdata: 32'h0,
        io_cfg: status_reply_pkg::IO_CFG_RST,
        rf_cfg: status_reply_pkg::RF_CFG_RST,
        pres_cfg: status_reply_pkg::PRES_CFG_RST,
        filt_cfg: status_reply_pkg::FILT_CFG_RST,
        out_cfg: status_reply_pkg::OUT_CFG_RST,
        in_meta: 2'h0, in_sync: 2'h0};
    end else begin
      s_reg <= s_next;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  // Checks on the stored settings and the emitted bytes
  pulse_code_legal_a: assert property (
    io_pulse != status_reply_pkg::PULSE_UNDEF)
    else $error("pulse code E stored");
  timeout_default_a: assert property (
    $past(SRST) |-> pres_to == status_reply_pkg::TO_INFINITE)
    else $error("radio timeout not TF after reset");
  atten_range_a: assert property (
    rf_att_a <= status_reply_pkg::ATT_MAX
    && rf_att_b <= status_reply_pkg::ATT_MAX)
    else $error("attenuation above 06");
  uniq_code_a: assert property (
    rf_uniq != 2'h0)
    else $error("uniqueness code T0 stored");
  sep_range_a: assert property (
    filt_sep <= status_reply_pkg::SEP_MAX)
    else $error("separation code above U4");
  interval_nonzero_a: assert property (
    out_ivl != 8'h00)
    else $error("retransmit interval 00");
  io_ctrl_byte_a: assert property (
    TX_VALID && s_reg.kind == status_reply_pkg::K_IO
    && s_reg.idx == 6'h06
    |-> TX_DATA == (io_ctrl ? 8'h31 : 8'h30))
    else $error("control byte wrong");
  io_out_byte_a: assert property (
    TX_VALID && s_reg.kind == status_reply_pkg::K_IO
    && s_reg.idx == 6'h09 |-> TX_DATA == 8'h30 + {6'h0, io_outs})
    else $error("output byte wrong");
  pres_min_byte_a: assert property (
    TX_VALID && s_reg.kind == status_reply_pkg::K_PRES
    && s_reg.idx == 6'h09 |-> TX_DATA == status_reply_pkg::CH_ZERO)
    else $error("minimum presence byte not 0");
  line_end_a: assert property (
    tx_last |-> TX_DATA == status_reply_pkg::CH_LF
    ##1 CMD_READY && !TX_VALID)
    else $error("reply not closed by LF");
  first_tag_a: assert property (
    cmd_take && CMD_CODE == status_reply_pkg::CMD_RF
    |=> ##1 TX_VALID && TX_DATA == status_reply_pkg::CH_R)
    else $error("radio reply does not open with tag");

  rf_reply_c: cover property (
    tx_last && s_reg.kind == status_reply_pkg::K_RF);
  stall_c: cover property (TX_VALID && !TX_READY ##1 TX_VALID && TX_READY);
  foreign_cmd_c: cover property (cmd_take && !cmd_hit);
  retx_reply_c: cover property (
    tx_last && s_reg.kind == status_reply_pkg::K_RETX);

endmodule

`default_nettype wire

// ===== verification/reply_sink.sv
/*
  Reply sink: stands for the serial transmitter that takes reply bytes.
  Assumes one clock shared with the formatter; the bench reads q.
*/
`timescale 1ns/1ps
`default_nettype none

module reply_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Byte stream
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // Stall request from the bench
  input wire logic stall
);
  logic [7:0] q[$];

  // Takes bytes; stalls every other cycle so bytes must hold
  always @(posedge clk) begin
    if (tx_valid && tx_ready && !rst) q.push_back(tx_data);
    tx_ready <= rst ? 1'b0 : (stall ? !tx_ready : 1'b1);
  end
endmodule

`default_nettype wire

// ===== verification/test_reader_status_report_formatter.sv
/*
  Bench for the status reply formatter: APB setup, display commands,
  reply bytes compared with strings built here.
  Assumes the sink model collects every byte handed over.
*/
`timescale 1ns/1ps
`default_nettype none

module test_reader_status_report_formatter;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic cv = 1'b0;
  logic stall = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [11:0] code = 12'h000;
  logic [1:0] pins = 2'h1;
  logic [31:0] prdata, rd;
  logic pready, perr, cready, tv, tr, err;
  logic [7:0] td;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;

  // Reply tags as the package holds them, zero bytes skipped
  localparam logic [31:0] T_IO = status_reply_pkg::IO_STATE_REPLY_TAG;
  localparam logic [31:0] T_RF = status_reply_pkg::RADIO_STATE_REPLY_TAG;
  localparam logic [31:0] T_PR = status_reply_pkg::PRESENCE_STATE_REPLY_TAG;
  localparam logic [31:0] T_FI = status_reply_pkg::ID_FILTER_REPLY_TAG;
  localparam logic [31:0] T_MO = {8'h00,
    status_reply_pkg::SERIAL_TAG_OUTPUT_MODE_TAG};
  localparam logic [31:0] T_IV = {8'h00,
    status_reply_pkg::RETRANSMIT_INTERVAL_TAG};

  status_reply_formatter i_dut (.REF_CLK(clk), .SRST(srst), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(perr), .CMD_VALID(cv),
    .CMD_CODE(code), .CMD_READY(cready), .TX_VALID(tv), .TX_DATA(td),
    .TX_READY(tr), .IN_PIN(pins));

  reply_sink i_sink (.clk(clk), .rst(srst), .tx_valid(tv), .tx_data(td),
    .tx_ready(tr), .stall(stall));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // Hang guard, well above the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop;
    end
  end

  task report_and_stop;
    $display("checked=%0d failed=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // APB transfer, held until PREADY is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Ends on PREADY; only the hang guard ends a wait that never sees it
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // Issue a command, collect the reply, compare byte by byte
  task rsp(input logic [11:0] c, input logic [31:0] t, input string e);
    logic [7:0] x[$];
    int n;
    x.delete();
    for (n = 3; n >= 0; n--) begin
      if (t[n*8 +: 8] != 8'h00) x.push_back(t[n*8 +: 8]);
    end
    for (n = 0; n < e.len(); n++) x.push_back(e[n]);
    // Unknown command: no tag, no line end expected
    if (t != 32'h0) begin
      x.push_back(status_reply_pkg::CH_CR);
      x.push_back(status_reply_pkg::CH_LF);
    end
    @(posedge clk);
    cv <= 1'b1;
    code <= c;
    do begin
      @(posedge clk);
    end while (cready !== 1'b1);
    cv <= 1'b0;
    repeat (150) begin
      @(negedge clk);
      if (i_sink.q.size() > 0 && i_sink.q[$] == 8'h0A) break;
    end
    chk(i_sink.q.size(), x.size());
    for (n = 0; n < x.size() && n < i_sink.q.size(); n++) begin
      chk(i_sink.q[n], x[n]);
    end
    i_sink.q.delete();
  endtask

  // Main sequence: defaults, refusals, then every reply under stalls
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h000000F0);
    rsp(12'h215, T_IV, " 01");
    rsp(12'h214, T_MO, " 0");
    rsp(12'h211, T_PR, " P0 D0 A0 TF I0");
    rsp(12'h210, 32'h0, "");
    apb(1'b1, 8'h00, 32'h000000F5);
    apb(1'b1, 8'h00, 32'h000000E0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h000000F5);
    apb(1'b1, 8'h04, 32'h060A1F0F);
    apb(1'b1, 8'h08, 32'h00000105);
    apb(1'b1, 8'h0C, 32'h00000034);
    apb(1'b1, 8'h10, 32'h0000FF01);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, err}, 32'h1);
    stall <= 1'b1;
    rsp(12'h20E, T_IO, " C1 O2 I2 DF");
    rsp(12'h20F, T_RF, " C1 O1 T3 F000 R1F G0A A06 I00");
    rsp(12'h211, T_PR, " P1 D0 A2 T0 I1");
    rsp(12'h212, T_FI, " U4 V3");
    rsp(12'h214, T_MO, " 1");
    rsp(12'h215, T_IV, " FF");
    // Input1 alone, inverted by the presence setting
    @(posedge clk);
    pins <= 2'h2;
    rsp(12'h20E, T_IO, " C1 O2 I1 DF");
    report_and_stop;
  end
endmodule

`default_nettype wire
